// ### design/pfm_pkg.sv
package pfm_pkg;

  // Register addresses on the four-bit register select.
  localparam logic [3:0] ADDR_MODE_A   = 4'h0;
  localparam logic [3:0] ADDR_CSEL_A   = 4'h1;
  localparam logic [3:0] ADDR_CMD_A    = 4'h2;
  localparam logic [3:0] ADDR_AUX      = 4'h4;
  localparam logic [3:0] ADDR_INT      = 4'h5;
  localparam logic [3:0] ADDR_MODE_B   = 4'h8;
  localparam logic [3:0] ADDR_CSEL_B   = 4'h9;
  localparam logic [3:0] ADDR_CMD_B    = 4'ha;
  localparam logic [3:0] ADDR_IMASK    = 4'hc;
  localparam logic [3:0] ADDR_OPCFG    = 4'hd;
  localparam logic [3:0] ADDR_OPSET    = 4'he;
  localparam logic [3:0] ADDR_OPCLR    = 4'hf;

  // Field positions.
  localparam int AUX_BRG_SET   = 7;
  localparam int AUX_CT_MODE   = 6;
  localparam int AUX_SRC_HI    = 5;
  localparam int AUX_SRC_LO    = 4;
  localparam int MODE1_RTR     = 7;
  localparam int MODE1_IRQSEL  = 6;
  localparam int MODE2_RTS     = 5;
  localparam int CMD_MISC_HI   = 6;
  localparam int CMD_MISC_LO   = 4;
  localparam int OPC_PIN2_HI   = 1;
  localparam int OPC_PIN2_LO   = 0;
  localparam int OPC_PIN3_HI   = 3;
  localparam int OPC_PIN3_LO   = 2;
  localparam int OPC_PIN4      = 4;
  localparam int OPC_PIN5      = 5;
  localparam int OPC_PIN6      = 6;
  localparam int OPC_PIN7      = 7;

  localparam logic [2:0] CMD_RESET_PTR = 3'h1;

  // Two-bit selector codes.
  localparam logic [1:0] SEL_00 = 2'h0;
  localparam logic [1:0] SEL_01 = 2'h1;
  localparam logic [1:0] SEL_10 = 2'h2;
  localparam logic [1:0] SEL_11 = 2'h3;

  localparam logic [3:0] CSEL_EXT16 = 4'he;
  localparam logic [3:0] CSEL_EXT1  = 4'hf;

  localparam logic [7:0] RESET_BYTE  = 8'h00;
  localparam logic [7:0] AUX_RESET   = 8'h40;
  localparam logic [2:0] DIV16_LAST  = 3'h7;

  // Interrupt status bits.
  localparam int IRQ_PTR_A = 0;
  localparam int IRQ_PTR_B = 1;
  localparam int IRQ_WIDTH = 2;

endpackage : pfm_pkg

// ### design/pfm_sync.sv
module pfm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] stable
);

  logic [WIDTH-1:0] stageOne;
  logic [WIDTH-1:0] stageTwo;
  logic [WIDTH-1:0] stageThree;

  // A change is taken once the second and third stages agree.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      stageOne   <= '0;
      stageTwo   <= '0;
      stageThree <= '0;
      stable     <= '0;
    end
    else
    begin
      stageOne   <= async;
      stageTwo   <= stageOne;
      stageThree <= stageTwo;
      stable     <= (stageTwo & stageThree) | (stable & (stageTwo | stageThree));
    end
  end

endmodule : pfm_sync

// ### design/pfm_port_mux.sv
// The strobed register port and the register offsets were decided locally.
module pfm_port_mux (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  input  wire logic       crystalInput,
  input  wire logic       inPinTwo,
  input  wire logic       inPinThree,
  input  wire logic       inPinFour,
  input  wire logic       inPinFive,
  input  wire logic       txClockChanA,
  input  wire logic       txClock16ChanA,
  input  wire logic       rxClockChanA,
  input  wire logic       txClockChanB,
  input  wire logic       rxClockChanB,
  input  wire logic       counterReadyOut,
  input  wire logic       timerWave,
  input  wire logic       rxReadyChanA,
  input  wire logic       fifoFullChanA,
  input  wire logic       rxReadyChanB,
  input  wire logic       fifoFullChanB,
  input  wire logic       txReadyChanA,
  input  wire logic       txReadyChanB,
  input  wire logic       rtrChanA,
  input  wire logic       rtsChanA,
  input  wire logic       rtrChanB,
  input  wire logic       rtsChanB,
  output logic      [7:0] outPins,
  output logic            ctClock,
  output logic            ctTimerMode,
  output logic            extRxClkA,
  output logic            extTxClkA,
  output logic            extRxClkB,
  output logic            extTxClkB,
  output logic            baudSetTwo,
  output logic            irq
);

  localparam int IRQ_W = pfm_pkg::IRQ_WIDTH;

  logic [7:0]           modeFirstChanA;
  logic [7:0]           modeSecondChanA;
  logic [7:0]           modeFirstChanB;
  logic [7:0]           modeSecondChanB;
  logic [7:0]           clockSelectChanA;
  logic [7:0]           clockSelectChanB;
  logic [7:0]           auxControlReg;
  logic [7:0]           outputPinConfig;
  logic [7:0]           outputGeneralBits;
  logic                 ptrSecondA;
  logic                 ptrSecondB;
  logic [IRQ_W-1:0]     irqStatus;
  logic [IRQ_W-1:0]     irqMask;
  logic [2:0]           x1Div;
  logic [2:0]           ip2Div;
  logic                 x1Prev;
  logic                 ip2Prev;
  logic                 x1Div16;
  logic                 ip2Div16;
  logic [4:0]           pinSync;

  pfm_sync #(
    .WIDTH (5)
  ) i_pfm_sync (
    .mclk   (mclk),
    .nrst   (nrst),
    .async  ({crystalInput, inPinFive, inPinFour, inPinThree, inPinTwo}),
    .stable (pinSync)
  );

  wire x1Level  = pinSync[4];
  wire ip5Level = pinSync[3];
  wire ip4Level = pinSync[2];
  wire ip3Level = pinSync[1];
  wire ip2Level = pinSync[0];

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.

  wire wrModeA  = regWrite && regAddr == pfm_pkg::ADDR_MODE_A;
  wire wrModeB  = regWrite && regAddr == pfm_pkg::ADDR_MODE_B;
  wire accModeA = (regWrite || regRead) && regAddr == pfm_pkg::ADDR_MODE_A;
  wire accModeB = (regWrite || regRead) && regAddr == pfm_pkg::ADDR_MODE_B;
  wire wrCmdA   = regWrite && regAddr == pfm_pkg::ADDR_CMD_A;
  wire wrCmdB   = regWrite && regAddr == pfm_pkg::ADDR_CMD_B;
  wire wrCselA  = regWrite && regAddr == pfm_pkg::ADDR_CSEL_A;
  wire wrCselB  = regWrite && regAddr == pfm_pkg::ADDR_CSEL_B;
  wire wrAux    = regWrite && regAddr == pfm_pkg::ADDR_AUX;
  wire wrInt    = regWrite && regAddr == pfm_pkg::ADDR_INT;
  wire wrMask   = regWrite && regAddr == pfm_pkg::ADDR_IMASK;
  wire wrOpcfg  = regWrite && regAddr == pfm_pkg::ADDR_OPCFG;
  wire wrOpSet  = regWrite && regAddr == pfm_pkg::ADDR_OPSET;
  wire wrOpClr  = regWrite && regAddr == pfm_pkg::ADDR_OPCLR;

  wire [2:0] miscField = regWrData[pfm_pkg::CMD_MISC_HI:pfm_pkg::CMD_MISC_LO];
  wire rstPtrA = wrCmdA && miscField == pfm_pkg::CMD_RESET_PTR;
  wire rstPtrB = wrCmdB && miscField == pfm_pkg::CMD_RESET_PTR;

  ////////////////////////////////////////////////////////////////////////////
  // Mode registers behind the per-channel pointers.

  // The full byte is taken on each write, so the address/data bit can change
  // at any time without disturbing the other fields.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      modeFirstChanA  <= pfm_pkg::RESET_BYTE;
      modeSecondChanA <= pfm_pkg::RESET_BYTE;
      modeFirstChanB  <= pfm_pkg::RESET_BYTE;
      modeSecondChanB <= pfm_pkg::RESET_BYTE;
    end
    else
    begin
      if (wrModeA && !ptrSecondA)
        modeFirstChanA <= regWrData;
      if (wrModeA && ptrSecondA)
        modeSecondChanA <= regWrData;
      if (wrModeB && !ptrSecondB)
        modeFirstChanB <= regWrData;
      if (wrModeB && ptrSecondB)
        modeSecondChanB <= regWrData;
    end
  end

  // A reset command in the same cycle cannot coincide with a mode access.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ptrSecondA <= 1'b0;
      ptrSecondB <= 1'b0;
    end
    else
    begin
      if (rstPtrA)
        ptrSecondA <= 1'b0;
      else if (accModeA)
        ptrSecondA <= 1'b1;
      if (rstPtrB)
        ptrSecondB <= 1'b0;
      else if (accModeB)
        ptrSecondB <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Other writable registers.

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      clockSelectChanA  <= pfm_pkg::RESET_BYTE;
      clockSelectChanB  <= pfm_pkg::RESET_BYTE;
      auxControlReg     <= pfm_pkg::AUX_RESET;
      outputPinConfig   <= pfm_pkg::RESET_BYTE;
      outputGeneralBits <= pfm_pkg::RESET_BYTE;
      irqMask           <= '0;
    end
    else
    begin
      if (wrCselA)
        clockSelectChanA <= regWrData;
      if (wrCselB)
        clockSelectChanB <= regWrData;
      if (wrAux)
        auxControlReg <= regWrData;
      if (wrOpcfg)
        outputPinConfig <= regWrData;
      if (wrOpSet)
        outputGeneralBits <= outputGeneralBits | regWrData;
      else if (wrOpClr)
        outputGeneralBits <= outputGeneralBits & ~regWrData;
      if (wrMask)
        irqMask <= regWrData[IRQ_W-1:0];
    end
  end

  // Pointer-reset commands are the events; set wins over a clearing write.
  wire [IRQ_W-1:0] irqEvents = {rstPtrB, rstPtrA};
  wire [IRQ_W-1:0] irqClear  = wrInt ? regWrData[IRQ_W-1:0] : '0;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      irqStatus <= '0;
    else
      irqStatus <= (irqStatus & ~irqClear) | irqEvents;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  wire [7:0] modeReadA = ptrSecondA ? modeSecondChanA : modeFirstChanA;
  wire [7:0] modeReadB = ptrSecondB ? modeSecondChanB : modeFirstChanB;
  logic [7:0] next_rdData;

  always_comb
  begin
    next_rdData = pfm_pkg::RESET_BYTE;
    case (regAddr)
      pfm_pkg::ADDR_MODE_A: next_rdData = modeReadA;
      pfm_pkg::ADDR_MODE_B: next_rdData = modeReadB;
      pfm_pkg::ADDR_CMD_A:  next_rdData = clockSelectChanA;
      pfm_pkg::ADDR_CMD_B:  next_rdData = clockSelectChanB;
      pfm_pkg::ADDR_AUX:    next_rdData = auxControlReg;
      pfm_pkg::ADDR_INT:    next_rdData = {{(8-IRQ_W){1'b0}}, irqStatus};
      pfm_pkg::ADDR_IMASK:  next_rdData = {{(8-IRQ_W){1'b0}}, irqMask};
      pfm_pkg::ADDR_OPCFG:  next_rdData = outputPinConfig;
      default:              next_rdData = pfm_pkg::RESET_BYTE;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      regRdData <= pfm_pkg::RESET_BYTE;
    else
      regRdData <= regRead ? next_rdData : pfm_pkg::RESET_BYTE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divide-by-16 of the crystal and of input pin two.

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      x1Prev   <= 1'b0;
      ip2Prev  <= 1'b0;
      x1Div    <= '0;
      ip2Div   <= '0;
      x1Div16  <= 1'b0;
      ip2Div16 <= 1'b0;
    end
    else
    begin
      x1Prev  <= x1Level;
      ip2Prev <= ip2Level;
      if (x1Level && !x1Prev)
      begin
        x1Div <= x1Div + 3'h1;
        if (x1Div == pfm_pkg::DIV16_LAST)
          x1Div16 <= ~x1Div16;
      end
      if (ip2Level && !ip2Prev)
      begin
        ip2Div <= ip2Div + 3'h1;
        if (ip2Div == pfm_pkg::DIV16_LAST)
          ip2Div16 <= ~ip2Div16;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter/timer clock and pin selection.

  function automatic logic pick4(input logic [1:0] sel, input logic a, input logic b,
                                 input logic c, input logic d);
    pick4 = (sel == pfm_pkg::SEL_00) ? a :
            (sel == pfm_pkg::SEL_01) ? b :
            (sel == pfm_pkg::SEL_10) ? c : d;
  endfunction : pick4

  wire       timerMode = auxControlReg[pfm_pkg::AUX_CT_MODE];
  wire [1:0] srcSel    = auxControlReg[pfm_pkg::AUX_SRC_HI:pfm_pkg::AUX_SRC_LO];
  wire counterClk = pick4(srcSel, ip2Level, txClockChanA, txClockChanB, x1Div16);
  wire timerClk   = pick4(srcSel, ip2Level, ip2Div16, x1Level, x1Div16);
  wire next_ctClock = timerMode ? timerClk : counterClk;

  wire [1:0] pin3Sel = outputPinConfig[pfm_pkg::OPC_PIN3_HI:pfm_pkg::OPC_PIN3_LO];
  wire [1:0] pin2Sel = outputPinConfig[pfm_pkg::OPC_PIN2_HI:pfm_pkg::OPC_PIN2_LO];
  wire ctOut = timerMode ? timerWave : counterReadyOut;

  // Port register bits are inverted onto the pins: a one drives the pin low.
  wire [7:0] gp = ~outputGeneralBits;
  wire [7:0] next_pins;
  assign next_pins[0] = (modeFirstChanA[pfm_pkg::MODE1_RTR] ? rtrChanA : 1'b1) &
                        (modeSecondChanA[pfm_pkg::MODE2_RTS] ? rtsChanA : 1'b1) &
                        (modeFirstChanA[pfm_pkg::MODE1_RTR] |
                         modeSecondChanA[pfm_pkg::MODE2_RTS] | gp[0]);
  assign next_pins[1] = (modeFirstChanB[pfm_pkg::MODE1_RTR] ? rtrChanB : 1'b1) &
                        (modeSecondChanB[pfm_pkg::MODE2_RTS] ? rtsChanB : 1'b1) &
                        (modeFirstChanB[pfm_pkg::MODE1_RTR] |
                         modeSecondChanB[pfm_pkg::MODE2_RTS] | gp[1]);
  assign next_pins[2] = pick4(pin2Sel, gp[2], txClock16ChanA, txClockChanA,
                              rxClockChanA);
  assign next_pins[3] = pick4(pin3Sel, gp[3], ctOut, txClockChanB, rxClockChanB);
  assign next_pins[4] = !outputPinConfig[pfm_pkg::OPC_PIN4] ? gp[4] :
                        modeFirstChanA[pfm_pkg::MODE1_IRQSEL] ? fifoFullChanA :
                        rxReadyChanA;
  assign next_pins[5] = !outputPinConfig[pfm_pkg::OPC_PIN5] ? gp[5] :
                        modeFirstChanB[pfm_pkg::MODE1_IRQSEL] ? fifoFullChanB :
                        rxReadyChanB;
  assign next_pins[6] = outputPinConfig[pfm_pkg::OPC_PIN6] ? txReadyChanA : gp[6];
  assign next_pins[7] = outputPinConfig[pfm_pkg::OPC_PIN7] ? txReadyChanB : gp[7];

  function automatic logic extSel(input logic [3:0] code);
    extSel = (code == pfm_pkg::CSEL_EXT16) || (code == pfm_pkg::CSEL_EXT1);
  endfunction : extSel

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      outPins     <= ~pfm_pkg::RESET_BYTE;
      ctClock     <= 1'b0;
      ctTimerMode <= pfm_pkg::AUX_RESET[pfm_pkg::AUX_CT_MODE];
      extRxClkA   <= 1'b0;
      extTxClkA   <= 1'b0;
      extRxClkB   <= 1'b0;
      extTxClkB   <= 1'b0;
      baudSetTwo  <= pfm_pkg::AUX_RESET[pfm_pkg::AUX_BRG_SET];
      irq         <= 1'b0;
    end
    else
    begin
      outPins     <= next_pins;
      ctClock     <= next_ctClock;
      ctTimerMode <= timerMode;
      extRxClkA   <= extSel(clockSelectChanA[7:4]) & ip4Level;
      extTxClkA   <= extSel(clockSelectChanA[3:0]) & ip3Level;
      extRxClkB   <= extSel(clockSelectChanB[7:4]) & ip2Level;
      extTxClkB   <= extSel(clockSelectChanB[3:0]) & ip5Level;
      baudSetTwo  <= auxControlReg[pfm_pkg::AUX_BRG_SET];
      irq         <= |(irqStatus & irqMask);
    end
  end

endmodule : pfm_port_mux

// ### testbench/pfm_port_mux_assertions.sv
module pfm_port_mux_assertions (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdData,
  input wire logic       txClockChanA,
  input wire logic       counterReadyOut,
  input wire logic       timerWave,
  input wire logic       txReadyChanA,
  input wire logic       txReadyChanB,
  input wire logic [7:0] outPins,
  input wire logic       ctTimerMode,
  input wire logic       baudSetTwo,
  input wire logic       irq
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] opc;
  logic [7:0] gen;
  logic       auxMode;
  wire        wrOpc  = regWrite && (regAddr == pfm_pkg::ADDR_OPCFG);
  wire        wrSet  = regWrite && (regAddr == pfm_pkg::ADDR_OPSET);
  wire        wrClr  = regWrite && (regAddr == pfm_pkg::ADDR_OPCLR);
  wire        wrAux  = regWrite && (regAddr == pfm_pkg::ADDR_AUX);
  wire        wrMask = regWrite && (regAddr == pfm_pkg::ADDR_IMASK);

  // Shadow copies of the pin configuration, general bits and mode bit, rebuilt from bus writes.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      opc <= 8'h00;
      gen <= 8'h00;
      auxMode <= pfm_pkg::AUX_RESET[pfm_pkg::AUX_CT_MODE];
    end
    else
    begin
      if (wrAux) auxMode <= regWrData[pfm_pkg::AUX_CT_MODE];
      if (wrOpc) opc <= regWrData;
      if (wrSet) gen <= gen | regWrData;
      else if (wrClr) gen <= gen & ~regWrData;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  rd_idle_zero_a:
    assert property (!regRead |=> regRdData == 8'h00)
    else $error("read data not zero outside a read answer");
  ct_mode_bit_a:
    assert property (wrAux |-> ##2 ctTimerMode == $past(regWrData[6], 2))
    else $error("counter or timer mode does not follow aux bit six");
  baud_set_bit_a:
    assert property (wrAux |-> ##2 baudSetTwo == $past(regWrData[7], 2))
    else $error("baud set does not follow aux bit seven");
  pin_six_ready_a:
    assert property ($past(opc[6]) |-> outPins[6] == $past(txReadyChanA))
    else $error("pin six does not show channel A transmit ready");
  pin_seven_ready_a:
    assert property ($past(opc[7]) |-> outPins[7] == $past(txReadyChanB))
    else $error("pin seven does not show channel B transmit ready");
  pin_three_ct_a:
    assert property ($past(opc[3:2]) == 2'h1 |-> outPins[3] ==
      ($past(auxMode) ? $past(timerWave) : $past(counterReadyOut)))
    else $error("pin three does not show the counter or timer output");
  pin_two_clock_a:
    assert property ($past(opc[1:0]) == 2'h2 |-> outPins[2] == $past(txClockChanA))
    else $error("pin two does not show the channel A transmit clock");
  pin_five_gen_a:
    assert property (!$past(opc[5]) |-> outPins[5] == !$past(gen[5]))
    else $error("pin five does not follow its general bit");
  irq_masked_a:
    assert property (wrMask && regWrData[1:0] == 2'h0 |-> ##2 !irq)
    else $error("interrupt stays high with every source masked");
endmodule : pfm_port_mux_assertions

bind pfm_port_mux pfm_port_mux_assertions i_pfm_port_mux_assertions (
  .mclk(mclk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
  .regRead(regRead), .regRdData(regRdData), .txClockChanA(txClockChanA),
  .counterReadyOut(counterReadyOut), .timerWave(timerWave), .txReadyChanA(txReadyChanA),
  .txReadyChanB(txReadyChanB), .outPins(outPins), .ctTimerMode(ctTimerMode),
  .baudSetTwo(baudSetTwo), .irq(irq)
);

// ### testbench/pfm_host_model.sv
module pfm_host_model (
  input  wire logic       mclk,
  input  wire logic [7:0] regRdData,
  output logic      [3:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            regWrite,
  output logic            regRead
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    regAddr = 4'h0;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
  end

  // Released address and data lines show the inverse of the last value.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(posedge mclk);
    d = regRdData;
  endtask : rd
endmodule : pfm_host_model

// ### testbench/test_port_function_mux_and_mode_pointer.sv
module test_port_function_mux_and_mode_pointer;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  regAddr;
  logic [7:0]  regWrData;
  logic        regWrite;
  logic        regRead;
  logic [7:0]  regRdData;
  logic [21:0] sig = 22'h0;
  logic [7:0]  outPins;
  logic        ctClock;
  logic        ctTimerMode;
  logic        baudSetTwo;
  logic        irq;
  logic [3:0]  extClk;
  logic [7:0]  rdv;
  logic [7:0]  opcs [3] = '{8'hf6, 8'h0f, 8'h09};
  logic [7:0]  auxT [6] = '{8'h00, 8'h10, 8'h20, 8'h40, 8'h60, 8'he0};
  logic [21:0] mskT [6] = '{22'h4, 22'h1, 22'h2, 22'h4, 22'h8, 22'h8};
  int          fails = 0;
  int          total_checks = 0;

  always #10 mclk = ~mclk;

  pfm_host_model i_pfm_host_model (
    .mclk(mclk), .regRdData(regRdData), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead)
  );

  pfm_port_mux i_pfm_port_mux (
    .mclk(mclk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .crystalInput(sig[3]), .inPinTwo(sig[2]), .inPinThree(sig[19]), .inPinFour(sig[20]),
    .inPinFive(sig[21]), .txClockChanA(sig[0]), .txClock16ChanA(sig[4]),
    .rxClockChanA(sig[5]), .txClockChanB(sig[1]), .rxClockChanB(sig[6]),
    .counterReadyOut(sig[7]), .timerWave(sig[8]), .rxReadyChanA(sig[9]),
    .fifoFullChanA(sig[10]), .rxReadyChanB(sig[11]), .fifoFullChanB(sig[12]),
    .txReadyChanA(sig[13]), .txReadyChanB(sig[14]), .rtrChanA(sig[15]), .rtsChanA(sig[16]),
    .rtrChanB(sig[17]), .rtsChanB(sig[18]), .outPins(outPins), .ctClock(ctClock),
    .ctTimerMode(ctTimerMode), .extRxClkA(extClk[3]), .extTxClkA(extClk[2]),
    .extRxClkB(extClk[1]), .extTxClkB(extClk[0]), .baudSetTwo(baudSetTwo), .irq(irq)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_pfm_host_model.wr(a, d);
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    i_pfm_host_model.rd(a, rdv);
    chk(rdv, exp);
  endtask : rdc

  // Pin levels expected with both mode register sets cleared and general bits clear.
  function automatic logic [7:0] expPins(input logic [7:0] c, input logic tm);
    logic [3:0] p3;
    logic [3:0] p2;
    p3 = {sig[6], sig[1], tm ? sig[8] : sig[7], 1'b1};
    p2 = {sig[5], sig[0], sig[4], 1'b1};
    return {c[7] ? sig[14] : 1'b1, c[6] ? sig[13] : 1'b1, c[5] ? sig[11] : 1'b1,
            c[4] ? sig[9] : 1'b1, p3[c[3:2]], p2[c[1:0]], 2'b11};
  endfunction : expPins

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (20000) @(posedge mclk);
    fails++;
    $display("[ERR] %0t run limit reached", $time);
    close_out();
  end

  initial
  begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    chk(outPins, 8'hff);
    chk({7'h0, ctTimerMode}, 8'h01);
    rdc(pfm_pkg::ADDR_AUX, 8'h40);
    rdc(4'h3, 8'h00);
    wr(pfm_pkg::ADDR_OPSET, 8'h24);
    wt(2);
    chk(outPins, 8'hdb);
    wr(pfm_pkg::ADDR_OPCLR, 8'h04);
    wt(2);
    chk(outPins, 8'hdf);
    wr(pfm_pkg::ADDR_OPCLR, 8'h20);
    for (int a = 0; a < 2; a++)
    begin
      wr(pfm_pkg::ADDR_AUX, a ? 8'h00 : 8'h40);
      for (int c = 0; c < 3; c++)
      begin
        wr(pfm_pkg::ADDR_OPCFG, opcs[c]);
        for (int p = 0; p < 2; p++)
        begin
          sig <= p ? 22'h155555 : 22'h2aaaaa;
          wt(2);
          chk(outPins, expPins(opcs[c], a == 0));
        end
      end
    end
    wr(pfm_pkg::ADDR_OPCFG, 8'h00);
    sig <= 22'h0;
    // Receivers and transmitters are reset before clock or baud set changes.
    wr(pfm_pkg::ADDR_CMD_A, 8'h20);
    wr(pfm_pkg::ADDR_CMD_A, 8'h30);
    wr(pfm_pkg::ADDR_CMD_B, 8'h20);
    wr(pfm_pkg::ADDR_CMD_B, 8'h30);
    for (int k = 0; k < 6; k++)
    begin
      wr(pfm_pkg::ADDR_AUX, auxT[k]);
      sig <= mskT[k];
      wt(8);
      chk({5'h0, baudSetTwo, ctTimerMode, ctClock}, {5'h0, auxT[k][7:6], 1'b1});
      sig <= 22'h0;
      wt(8);
      chk({5'h0, baudSetTwo, ctTimerMode, ctClock}, {5'h0, auxT[k][7:6], 1'b0});
    end
    // A second reset clears the dividers, so eight rising edges flip each divided clock.
    nrst <= 1'b0;
    wt(2);
    nrst <= 1'b1;
    wt(1);
    chk(outPins, 8'hff);
    rdc(pfm_pkg::ADDR_AUX, 8'h40);
    for (int k = 0; k < 2; k++)
    begin
      wr(pfm_pkg::ADDR_AUX, k ? 8'h50 : 8'h30);
      repeat (8)
      begin
        sig <= k ? 22'h4 : 22'h8;
        wt(3);
        sig <= 22'h0;
        wt(3);
      end
      wt(8);
      chk({6'h0, ctTimerMode, ctClock}, {6'h0, k == 1, 1'b1});
    end
    wr(pfm_pkg::ADDR_AUX, 8'h70);
    wt(3);
    chk({6'h0, ctTimerMode, ctClock}, 8'h03);
    wr(pfm_pkg::ADDR_CSEL_A, 8'hff);
    wr(pfm_pkg::ADDR_CSEL_B, 8'hef);
    sig <= 22'h380004;
    wt(8);
    chk({4'h0, extClk}, 8'h0f);
    sig <= 22'h0;
    wt(8);
    chk({4'h0, extClk}, 8'h00);
    sig <= 22'h380004;
    wr(pfm_pkg::ADDR_CSEL_A, 8'hdd);
    wt(8);
    chk({4'h0, extClk}, 8'h03);
    rdc(pfm_pkg::ADDR_CMD_A, 8'hdd);
    rdc(pfm_pkg::ADDR_CMD_B, 8'hef);
    sig <= 22'h0;
    wr(pfm_pkg::ADDR_MODE_A, 8'hdc);
    wr(pfm_pkg::ADDR_MODE_A, 8'h05);
    rdc(pfm_pkg::ADDR_MODE_A, 8'h05);
    wr(pfm_pkg::ADDR_MODE_B, 8'h33);
    wr(pfm_pkg::ADDR_CMD_A, 8'h10);
    rdc(pfm_pkg::ADDR_MODE_B, 8'h00);
    rdc(pfm_pkg::ADDR_MODE_A, 8'hdc);
    rdc(pfm_pkg::ADDR_MODE_A, 8'h05);
    wr(pfm_pkg::ADDR_CMD_B, 8'h10);
    rdc(pfm_pkg::ADDR_MODE_B, 8'h33);
    wr(pfm_pkg::ADDR_OPCFG, 8'h10);
    sig <= 22'h000400;
    wt(2);
    chk(outPins & 8'h11, 8'h10);
    sig <= 22'h008200;
    wt(2);
    chk(outPins & 8'h11, 8'h01);
    wr(pfm_pkg::ADDR_IMASK, 8'h03);
    wr(pfm_pkg::ADDR_INT, 8'hff);
    wt(3);
    chk({7'h0, irq}, 8'h00);
    wr(pfm_pkg::ADDR_CMD_A, 8'h10);
    wt(3);
    chk({7'h0, irq}, 8'h01);
    rdc(pfm_pkg::ADDR_INT, 8'h01);
    wr(pfm_pkg::ADDR_IMASK, 8'h00);
    wt(3);
    chk({7'h0, irq}, 8'h00);
    wr(pfm_pkg::ADDR_IMASK, 8'h03);
    wt(3);
    chk({7'h0, irq}, 8'h01);
    wr(pfm_pkg::ADDR_INT, 8'h01);
    wt(3);
    chk({7'h0, irq}, 8'h00);
    close_out();
  end
endmodule : test_port_function_mux_and_mode_pointer
